// ---- rtib_params.svh ----
`ifndef RTIB_PARAMS_SVH
`define RTIB_PARAMS_SVH

// Register offsets on the serial control register port
`define RTIB_ADDR_RAMP_STS 8'h0e
`define RTIB_ADDR_RAMP_MSK 8'h0f
`define RTIB_ADDR_RAMP_SNS 8'h10
`define RTIB_ADDR_LIN_STS 8'h18
`define RTIB_ADDR_LIN_MSK 8'h19
`define RTIB_ADDR_LIN_SNS 8'h1a
`define RTIB_ADDR_THM_STS 8'h20
`define RTIB_ADDR_THM_MSK 8'h21
`define RTIB_ADDR_THM_SNS 8'h22

// Field positions inside the thermal registers
`define RTIB_THM_LOW_BIT 0
`define RTIB_THM_HIGH_BIT 2

// Reset values: masks come up set, everything else clear
`define RTIB_RST_RAMP_MSK 2'h3
`define RTIB_RST_LIN_MSK 3'h7
`define RTIB_RST_THM_MSK 2'h3
`define RTIB_RST_STS 8'h00

`endif

// ---- rtib_pkg.sv ----
package rtib_pkg;

  // One access from the serial control interface
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtib_req_s;

  // Raw condition levels from the analogue side
  typedef struct packed {
    logic [1:0] die_above;
    logic [2:0] lin_ilim_live;
    logic [1:0] ramp_active;
  } rtib_live_s;

  // Whole state of the interrupt bank
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] prev;
    logic [1:0] ramp_sts;
    logic [1:0] ramp_msk;
    logic [2:0] lin_sts;
    logic [2:0] lin_msk;
    logic [1:0] thm_sts;
    logic [1:0] thm_msk;
    logic [7:0] rdata;
    logic irq_n;
  } rtib_state_s;

endpackage

// ---- rtib_irq_bank.sv ----
// Summary of operation
// - Each finished voltage ramp on buck one or buck two sets its ramp-done event.
// - Ramp-done status holds buck one in bit 0, buck two in bit 1.
// - A status bit clears when the host reads it or writes 1 there.
// - A set status bit stays at 1 until cleared, whatever the condition does.
// - Mask 0 lets a set status bit pull the interrupt low; 1 blocks it.
// - Ramp-done masks sit in bits 0 and 1 and reset to masked.
// - Ramp sense shows 1 per buck while its ramp is running, reset 0.
// - Linear fault status latches current-limit events of regulators one to three.
// - Linear fault masks sit in bits 0 to 2 and reset to masked.
// - Linear fault sense shows the live fault level of each regulator.
// - Thermal status latches 110 and 125 degree crossings, either direction, bits 0, 2.
// - Thermal masks sit in bits 0 and 2, reset to 1.
`timescale 1ns/1ns
`include "rtib_params.svh"

module rtib_irq_bank (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire rtib_pkg::rtib_req_s i_req,
  input wire rtib_pkg::rtib_live_s i_live,
  output logic [7:0] o_reg_rdata,
  output logic o_irq_out_n
);
  import rtib_pkg::*;

  localparam int NUM_SRC = 7;

  rtib_state_s st_r;
  rtib_state_s st_nxt;

  logic [NUM_SRC-1:0] rise_w;
  logic [NUM_SRC-1:0] fall_w;
  logic [NUM_SRC-1:0] live_w;

  // Flatten the live levels so one loop can treat every source alike
  assign live_w = i_live;

  // Edge detectors work on the second synchroniser stage and its delayed copy
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_edge
      assign rise_w[gi] = st_r.sync2[gi] & ~st_r.prev[gi];
      assign fall_w[gi] = st_r.prev[gi] & ~st_r.sync2[gi];
    end
  endgenerate

  // Next-state logic for the whole bank
  always_comb begin
    logic [1:0] ramp_set;
    logic [2:0] lin_set;
    logic [1:0] thm_set;
    logic [1:0] ramp_clr;
    logic [2:0] lin_clr;
    logic [1:0] thm_clr;
    logic [7:0] thm_rd;
    logic pend;
    ramp_set = 2'h0;
    lin_set = 3'h0;
    thm_set = 2'h0;
    ramp_clr = 2'h0;
    lin_clr = 3'h0;
    thm_clr = 2'h0;
    thm_rd = 8'h00;
    pend = 1'b0;
    st_nxt = st_r;

    // Two flops on every analogue level before any logic looks at it
    st_nxt.sync1 = live_w;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;

    // A ramp is done when its in-progress level drops, one event per change
    ramp_set = fall_w[1:0];
    // Current limit is flagged on the fault's arrival
    lin_set = rise_w[4:2];
    // Thermal crossings count both ways
    thm_set = rise_w[6:5] | fall_w[6:5];

    // Read-to-clear takes exactly the bits the host was shown
    if (i_req.rd) begin
      case (i_req.addr)
        `RTIB_ADDR_RAMP_STS: begin
          ramp_clr = st_r.ramp_sts;
        end
        `RTIB_ADDR_LIN_STS: begin
          lin_clr = st_r.lin_sts;
        end
        `RTIB_ADDR_THM_STS: begin
          thm_clr = st_r.thm_sts;
        end
        default: begin
          ramp_clr = 2'h0;
        end
      endcase
    end

    // Writes: ones clear status, masks take the written bits
    if (i_req.wr) begin
      case (i_req.addr)
        `RTIB_ADDR_RAMP_STS: begin
          ramp_clr = ramp_clr | i_req.wdata[1:0];
        end
        `RTIB_ADDR_LIN_STS: begin
          lin_clr = lin_clr | i_req.wdata[2:0];
        end
        `RTIB_ADDR_THM_STS: begin
          thm_clr[0] = thm_clr[0] | i_req.wdata[`RTIB_THM_LOW_BIT];
          thm_clr[1] = thm_clr[1] | i_req.wdata[`RTIB_THM_HIGH_BIT];
        end
        `RTIB_ADDR_RAMP_MSK: begin
          st_nxt.ramp_msk = i_req.wdata[1:0];
        end
        `RTIB_ADDR_LIN_MSK: begin
          st_nxt.lin_msk = i_req.wdata[2:0];
        end
        `RTIB_ADDR_THM_MSK: begin
          st_nxt.thm_msk[0] = i_req.wdata[`RTIB_THM_LOW_BIT];
          st_nxt.thm_msk[1] = i_req.wdata[`RTIB_THM_HIGH_BIT];
        end
        default: begin
          st_nxt.rdata = st_nxt.rdata; // Sense and unmapped offsets ignore writes
        end
      endcase
    end

    // Sticky update; a new event beats a clear in the same cycle
    st_nxt.ramp_sts = (st_r.ramp_sts & ~ramp_clr) | ramp_set;
    st_nxt.lin_sts = (st_r.lin_sts & ~lin_clr) | lin_set;
    st_nxt.thm_sts = (st_r.thm_sts & ~thm_clr) | thm_set;

    // Read data is registered and holds until the next read
    if (i_req.rd) begin
      case (i_req.addr)
        `RTIB_ADDR_RAMP_STS: begin
          st_nxt.rdata = {6'h00, st_r.ramp_sts};
        end
        `RTIB_ADDR_RAMP_MSK: begin
          st_nxt.rdata = {6'h00, st_r.ramp_msk};
        end
        `RTIB_ADDR_RAMP_SNS: begin
          st_nxt.rdata = {6'h00, st_r.sync2[1:0]};
        end
        `RTIB_ADDR_LIN_STS: begin
          st_nxt.rdata = {5'h00, st_r.lin_sts};
        end
        `RTIB_ADDR_LIN_MSK: begin
          st_nxt.rdata = {5'h00, st_r.lin_msk};
        end
        `RTIB_ADDR_LIN_SNS: begin
          st_nxt.rdata = {5'h00, st_r.sync2[4:2]};
        end
        `RTIB_ADDR_THM_STS: begin
          thm_rd[`RTIB_THM_LOW_BIT] = st_r.thm_sts[0];
          thm_rd[`RTIB_THM_HIGH_BIT] = st_r.thm_sts[1];
          st_nxt.rdata = thm_rd;
        end
        `RTIB_ADDR_THM_MSK: begin
          thm_rd[`RTIB_THM_LOW_BIT] = st_r.thm_msk[0];
          thm_rd[`RTIB_THM_HIGH_BIT] = st_r.thm_msk[1];
          st_nxt.rdata = thm_rd;
        end
        `RTIB_ADDR_THM_SNS: begin
          thm_rd[`RTIB_THM_LOW_BIT] = st_r.sync2[5];
          thm_rd[`RTIB_THM_HIGH_BIT] = st_r.sync2[6];
          st_nxt.rdata = thm_rd;
        end
        default: begin
          st_nxt.rdata = 8'h00; // Unmapped offsets read zero
        end
      endcase
    end

    // Output follows the next status so the pin needs no extra cycle
    pend = |(st_nxt.ramp_sts & ~st_nxt.ramp_msk) |
           |(st_nxt.lin_sts & ~st_nxt.lin_msk) |
           |(st_nxt.thm_sts & ~st_nxt.thm_msk);
    st_nxt.irq_n = ~pend;
  end

  // The only state register; masks come up set so nothing fires after reset
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
      // Status reset value is byte wide; each group keeps only its own bits
      st_r.ramp_sts <= 2'(`RTIB_RST_STS);
      st_r.lin_sts <= 3'(`RTIB_RST_STS);
      st_r.thm_sts <= 2'(`RTIB_RST_STS);
      st_r.ramp_msk <= `RTIB_RST_RAMP_MSK;
      st_r.lin_msk <= `RTIB_RST_LIN_MSK;
      st_r.thm_msk <= `RTIB_RST_THM_MSK;
      st_r.irq_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ports straight from the state flops
  assign o_reg_rdata = st_r.rdata;
  assign o_irq_out_n = st_r.irq_n;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Host access shapes used below
  sequence wr_ramp_sts_b0;
    i_req.wr && !i_req.rd && i_req.addr == `RTIB_ADDR_RAMP_STS && i_req.wdata[0] && !fall_w[0];
  endsequence

  sequence rd_lin_sts;
    i_req.rd && !i_req.wr && i_req.addr == `RTIB_ADDR_LIN_STS && st_r.lin_sts[0] && !rise_w[2];
  endsequence

  sequence no_ramp_touch;
    !(i_req.rd || i_req.wr) || i_req.addr != `RTIB_ADDR_RAMP_STS;
  endsequence

  sequence rd_ramp_sts_b0;
    i_req.rd && !i_req.wr && i_req.addr == `RTIB_ADDR_RAMP_STS && st_r.ramp_sts[0] && !fall_w[0];
  endsequence

  sequence wr_thm_sts_b2;
    i_req.wr && !i_req.rd && i_req.addr == `RTIB_ADDR_THM_STS && i_req.wdata[`RTIB_THM_HIGH_BIT] &&
      !rise_w[6] && !fall_w[6];
  endsequence

  sequence no_lin_touch;
    !(i_req.rd || i_req.wr) || i_req.addr != `RTIB_ADDR_LIN_STS;
  endsequence

  sequence rd_unmapped;
    i_req.rd && !(i_req.addr inside {`RTIB_ADDR_RAMP_STS, `RTIB_ADDR_RAMP_MSK, `RTIB_ADDR_RAMP_SNS,
      `RTIB_ADDR_LIN_STS, `RTIB_ADDR_LIN_MSK, `RTIB_ADDR_LIN_SNS,
      `RTIB_ADDR_THM_STS, `RTIB_ADDR_THM_MSK, `RTIB_ADDR_THM_SNS});
  endsequence

  sequence wr_lin_msk;
    i_req.wr && i_req.addr == `RTIB_ADDR_LIN_MSK;
  endsequence

  sequence wr_thm_msk;
    i_req.wr && i_req.addr == `RTIB_ADDR_THM_MSK;
  endsequence

  // Ramp completion lands in status one cycle later
  ramp_done_set_a: assert property (fall_w[0] |=> st_r.ramp_sts[0])
    else $error("ramp done event lost");

  // Write one clears the ramp bit
  ramp_w1c_a: assert property (wr_ramp_sts_b0 |=> !st_r.ramp_sts[0])
    else $error("write one did not clear");

  // Reading shows the bit and then it is gone
  lin_rdclr_a: assert property (rd_lin_sts |=> o_reg_rdata[0] && !st_r.lin_sts[0])
    else $error("read did not clear");

  // Untouched set bit stays for several cycles
  ramp_sticky_a: assert property (st_r.ramp_sts[1] ##0 no_ramp_touch [*3] |=> st_r.ramp_sts[1])
    else $error("status bit dropped on its own");

  // Pin matches unmasked pending status
  irq_level_a: assert property (o_irq_out_n == !(|(st_r.ramp_sts & ~st_r.ramp_msk) |
    |(st_r.lin_sts & ~st_r.lin_msk) | |(st_r.thm_sts & ~st_r.thm_msk)))
    else $error("interrupt pin disagrees with status");

  // Mask write takes effect and drops unused bits
  ramp_mask_wr_a: assert property (i_req.wr && i_req.addr == `RTIB_ADDR_RAMP_MSK
    |=> st_r.ramp_msk == $past(i_req.wdata[1:0]))
    else $error("ramp mask not written");

  // Sense read reflects synchronised level
  ramp_sense_a: assert property (i_req.rd && i_req.addr == `RTIB_ADDR_RAMP_SNS
    |=> o_reg_rdata == {6'h00, $past(st_r.sync2[1:0])})
    else $error("ramp sense wrong");

  // Linear fault arrival latched
  lin_fault_set_a: assert property (rise_w[3] |=> st_r.lin_sts[1])
    else $error("linear fault event lost");

  // Live fault level appears in sense read three cycles after the pin
  lin_sense_a: assert property (i_req.rd && i_req.addr == `RTIB_ADDR_LIN_SNS
    |=> o_reg_rdata[2:0] == $past(st_r.sync2[4:2]) && o_reg_rdata[7:3] == 5'h00)
    else $error("linear sense wrong");

  // Thermal drop also sets the event
  thm_fall_set_a: assert property (fall_w[6] |=> st_r.thm_sts[1])
    else $error("thermal falling crossing lost");

  // Thermal status read places bits at 0 and 2 only
  thm_layout_a: assert property (i_req.rd && i_req.addr == `RTIB_ADDR_THM_STS
    |=> o_reg_rdata[1] == 1'b0 && o_reg_rdata[7:3] == 5'h00 &&
    o_reg_rdata[2] == $past(st_r.thm_sts[1]))
    else $error("thermal status layout wrong");

  // Masked linear bit never pulls the pin
  lin_masked_a: assert property (st_r.lin_msk == 3'h7 && st_r.ramp_sts == 2'h0 && st_r.thm_sts == 2'h0
    |-> o_irq_out_n)
    else $error("masked source drove the pin");

  // Buck two ramp completion lands in its own bit
  ramp_two_set_a: assert property (fall_w[1] |=> st_r.ramp_sts[1])
    else $error("buck two ramp done event lost");

  // Read of ramp status clears what it showed
  ramp_rdclr_a: assert property (rd_ramp_sts_b0 |=> o_reg_rdata[0] && !st_r.ramp_sts[0])
    else $error("ramp read did not clear");

  // Write one on the high thermal bit clears it
  thm_w1c_a: assert property (wr_thm_sts_b2 |=> !st_r.thm_sts[1])
    else $error("thermal write one did not clear");

  // Linear bit survives while nobody touches its register
  lin_sticky_a: assert property (st_r.lin_sts[0] ##0 no_lin_touch [*2] |=> st_r.lin_sts[0])
    else $error("linear status bit dropped on its own");

  // Unmasked ramp bit holds the pin low
  ramp_unmasked_a: assert property (st_r.ramp_sts[0] && !st_r.ramp_msk[0] |-> !o_irq_out_n)
    else $error("unmasked ramp event left the pin high");

  // Linear arrivals and thermal crossings latched in their own bits
  lin_one_set_a: assert property (rise_w[2] |=> st_r.lin_sts[0])
    else $error("linear regulator one fault lost");
  lin_three_set_a: assert property (rise_w[4] |=> st_r.lin_sts[2])
    else $error("linear regulator three fault lost");
  thm_rise_set_a: assert property (rise_w[5] |=> st_r.thm_sts[0])
    else $error("thermal rising crossing lost");
  thm_low_fall_a: assert property (fall_w[5] |=> st_r.thm_sts[0])
    else $error("thermal low falling crossing lost");

  // Mask writes land and keep only the defined bits
  lin_mask_wr_a: assert property (wr_lin_msk |=> st_r.lin_msk == $past(i_req.wdata[2:0]))
    else $error("linear mask not written");

  thm_mask_wr_a: assert property (wr_thm_msk |=> st_r.thm_msk[1] == $past(i_req.wdata[2]) &&
    st_r.thm_msk[0] == $past(i_req.wdata[0]))
    else $error("thermal mask not written");

  // Unmapped offsets read as zero
  unmapped_rd_a: assert property (rd_unmapped |=> o_reg_rdata == 8'h00)
    else $error("unmapped offset returned data");

endmodule // rtib_irq_bank

// ---- rtib_ana_mdl.sv ----
`timescale 1ns/1ns
module rtib_ana_mdl (
  input wire logic i_core_clk,
  input wire logic [6:0] i_level,
  output rtib_pkg::rtib_live_s o_live
);
  import rtib_pkg::*;

  // Comparator outputs settle just after an edge, so the bank never sees them change on its sampling edge
  initial begin
    o_live = '0;
  end
  always @(posedge i_core_clk) begin
    #1 o_live <= i_level;
  end
endmodule // rtib_ana_mdl

// ---- rtib_irq_bank_tb.sv ----
`timescale 1ns/1ns
module rtib_irq_bank_tb;
  import rtib_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  rtib_req_s i_req = '0;
  rtib_live_s i_live;
  logic [6:0] lvl = 7'h00;
  logic [7:0] o_reg_rdata;
  logic o_irq_out_n;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  // 25 MHz core clock
  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end

  rtib_ana_mdl rtib_ana_mdl_i (.i_core_clk(i_core_clk), .i_level(lvl), .o_live(i_live));
  rtib_irq_bank rtib_irq_bank_i (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_req(i_req),
    .i_live(i_live), .o_reg_rdata(o_reg_rdata), .o_irq_out_n(o_irq_out_n));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write, one-cycle strobe; returns once the irq pin has settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1 i_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_core_clk);
    #1 i_req.wr = 1'b0;
    @(posedge i_core_clk);
    #1;
  endtask

  // Register read and compare of the returned byte
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    #1 i_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge i_core_clk);
    #1 i_req.rd = 1'b0;
    @(posedge i_core_clk);
    #1;
    chk(o_reg_rdata, exp);
  endtask

  task automatic irq(input logic exp);
    chk({7'h00, o_irq_out_n}, {7'h00, exp});
  endtask

  // Live levels as {die_above, lin_ilim_live, ramp_active}; wait covers model plus sync delay
  task automatic live(input logic [6:0] v);
    lvl = v;
    repeat (6) @(posedge i_core_clk);
    #1;
  endtask

  task automatic t_reset();
    rd(8'h0f, 8'h03);
    rd(8'h19, 8'h07);
    rd(8'h21, 8'h05);
    rd(8'h0e, 8'h00);
    rd(8'h30, 8'h00);
    irq(1'b1);
  endtask

  task automatic t_ramp();
    live(7'h03);
    rd(8'h10, 8'h03);
    live(7'h00);
    irq(1'b1);
    wr(8'h0f, 8'hfe);
    rd(8'h0f, 8'h02);
    irq(1'b0);
    rd(8'h0e, 8'h03);
    irq(1'b1);
    rd(8'h0e, 8'h00);
    live(7'h01);
    live(7'h00);
    irq(1'b0);
    wr(8'h0e, 8'h01);
    irq(1'b1);
    rd(8'h0e, 8'h00);
  endtask

  task automatic t_lin();
    wr(8'h19, 8'h00);
    live(7'h1c);
    rd(8'h1a, 8'h07);
    live(7'h00);
    rd(8'h1a, 8'h00);
    irq(1'b0);
    wr(8'h18, 8'h04);
    irq(1'b0);
    rd(8'h18, 8'h03);
    irq(1'b1);
  endtask

  task automatic t_therm();
    wr(8'h21, 8'h00);
    live(7'h60);
    rd(8'h22, 8'h05);
    rd(8'h20, 8'h05);
    live(7'h00);
    irq(1'b0);
    wr(8'h20, 8'hff);
    irq(1'b1);
    rd(8'h20, 8'h00);
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs about 120 cycles
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    repeat (5) @(posedge i_core_clk);
    #1 i_reset_n = 1'b1;
    t_reset();
    t_ramp();
    t_lin();
    t_therm();
    stop_test();
  end
endmodule // rtib_irq_bank_tb
